// [inc/ats_resp_consts.svh]
// register offsets, field positions, reset values and encodings for the ats responder
`ifndef ATS_RESP_CONSTS_SVH
`define ATS_RESP_CONSTS_SVH
`define OFF_GLOBAL_CTRL 6'h00
`define OFF_STREAM_CFG 6'h04
`define OFF_OVERRIDE 6'h08
`define OFF_FIXED_ATTR 6'h0C
`define OFF_STATUS 6'h10
`define OFF_REQ_COUNT 6'h14
`define OFF_XLT_COUNT 6'h18
`define OFF_FAULT_COUNT 6'h1C
`define CFG_CONFIG_LSB 0
`define CFG_ATS_LSB 4
`define CFG_DSS_LSB 8
`define CFG_CDMAX_LSB 12
`define CFG_OVR_EN_BIT 20
`define CTRL_CHECK_BIT 0
`define CTRL_ATTR_BIT 1
`define ATS_FULL 2'h1
`define ATS_SPLIT 2'h2
`define DSS_BYPASS 2'h1
`define CFG_NESTED 3'h7
`define CFG_S2_ONLY 2'h2
`define CFG_BOTH 2'h3
`define RST_GLOBAL_CTRL 2'h0
`define RST_STREAM_CFG 21'h000000
`define RST_FIXED_ATTR 8'hFF
`define RST_OVERRIDE 8'h00
`define OUT_ADDR_BITS 6'h30
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// [inc/ats_resp_pkg.sv]
// types shared by the ats split-stage responder
package ats_resp_pkg;
   typedef struct packed
   {
      logic [63:0] addr;
      logic no_write;
      logic pasid_present;
      logic exe_req;
      logic priv_req;
   } xlat_req_t;
   typedef struct packed
   {
      logic [63:0] addr;
      logic [5:0] size_log2;
      logic [7:0] attr;
      logic untranslated;
      logic rd;
      logic wr;
      logic exe;
      logic priv;
      logic no_snoop;
      logic abort;
   } xlat_cpl_t;
   typedef struct packed
   {
      logic [63:0] out_addr;
      logic [5:0] size_log2;
      logic [7:0] attr;
      logic rd;
      logic wr;
      logic exe;
      logic fault;
   } walk_res_t;
   typedef struct packed
   {
      logic [63:0] addr;
      logic [7:0] attr;
      logic is_write;
   } xlated_txn_t;
   typedef struct packed
   {
      logic [63:0] addr;
      logic [7:0] attr;
      logic is_write;
      logic fault;
   } out_txn_t;
   typedef enum logic [4:0]
   {
      ST_IDLE = 5'b00001,
      ST_S1 = 5'b00010,
      ST_S2 = 5'b00100,
      ST_CPL = 5'b01000,
      ST_TXN = 5'b10000
   } state_t;
endpackage

// [logic/ats_split_stage_responder.sv]
// ats translation request and translated transaction responder with axi4-lite registers
// What this block does
// - split mode, check on, nested config: completion carries intermediate address.
// - split completion address is stage 1 result, not the combined address.
// - split completion attribute yields combined attribute after stage 2.
// - nested or split permissions combine both stages, limited to request.
// - size at most smaller of stage 1 and stage 2 sizes; return maximum.
// - full mode translated transaction passes straight out as physical address.
// - split mode translated transaction goes through stage 2 and may fault.
// - with check enabled every translated transaction is checked against stream entry.
// - non-pasid traffic skips stage 1 under full mode with bypass select.
// - skip with stage 2 on: stage 2 only, return physical address.
// - skipped stage 1 attribute is fixed input, overridden, combined with stage 2.
// - skip with stage 2 off: identity completion, u=0, r=1, w=1.
// - identity completion size covers request, up to output address size.
// - skip case completions clear execute and privileged indications.
// - full skip attribute is fixed input with overrides, encoded at request.
// - split skip case: request address is intermediate, identity completion, u=0.
// - split skip read and write come from stage 2, limited to request.
// - split skip size at most stage 2 size; return maximum.
// - split skip attribute yields overridden input combined with stage 2.
// - with check enabled, later intermediate-address translated accesses use stage 2 only.
// - no-snoop in every completion is always zero.
//
// Added by the designer: register access over AXI4-Lite and the register addresses.
module ats_split_stage_responder
(
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite slave
   input wire logic [5:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [5:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // translation request and completion
   input wire logic req_valid,
   input wire ats_resp_pkg::xlat_req_t req,
   output logic req_ready,
   output logic cpl_valid,
   output ats_resp_pkg::xlat_cpl_t cpl,
   input wire logic cpl_ready,
   // translated transactions
   input wire logic txn_valid,
   input wire ats_resp_pkg::xlated_txn_t txn,
   output logic txn_ready,
   output logic out_valid,
   output ats_resp_pkg::out_txn_t out_txn,
   input wire logic out_ready,
   // table walker, one stage per query
   output logic walk_valid,
   output logic walk_stage2,
   output logic [63:0] walk_addr,
   input wire logic walk_done,
   input wire ats_resp_pkg::walk_res_t walk_res
);
`include "ats_resp_consts.svh"

   // ********************************
   // attribute combination
   // ********************************
   // weaker of two attributes per nibble: lower code means less cacheable
   function automatic logic [7:0] attr_combine(input logic [7:0] a, input logic [7:0] b);
      logic [3:0] hi;
      logic [3:0] lo;
      hi = (a[7:4] < b[7:4]) ? a[7:4] : b[7:4];
      lo = (a[3:0] < b[3:0]) ? a[3:0] : b[3:0];
      return {hi, lo};
   endfunction

   function automatic logic [5:0] size_min(input logic [5:0] a, input logic [5:0] b);
      return (a < b) ? a : b;
   endfunction

   // ********************************
   // registers
   // ********************************
   logic [1:0] gctrl_q;
   logic [20:0] scfg_q;
   logic [7:0] ovr_q;
   logic [7:0] fixed_q;
   logic [31:0] req_cnt_q;
   logic [31:0] xlt_cnt_q;
   logic [31:0] flt_cnt_q;
   logic misconfig_q;

   wire check_en = gctrl_q[`CTRL_CHECK_BIT];
   wire attr_en = gctrl_q[`CTRL_ATTR_BIT];
   wire [2:0] cfg = scfg_q[`CFG_CONFIG_LSB +: 3];
   wire [1:0] ats_mode = scfg_q[`CFG_ATS_LSB +: 2];
   wire [1:0] dss = scfg_q[`CFG_DSS_LSB +: 2];
   wire [4:0] cdmax = scfg_q[`CFG_CDMAX_LSB +: 5];
   wire ovr_en = scfg_q[`CFG_OVR_EN_BIT];
   wire [7:0] in_attr = ovr_en ? ovr_q : fixed_q;

   // ********************************
   // mode decode
   // ********************************
   // split mode with check disabled is a software fault; treated as full mode except on the split skip path
   wire split_mode = (ats_mode == `ATS_SPLIT) && check_en && (cfg == `CFG_NESTED);
   wire full_skip = cfg[0] && (ats_mode == `ATS_FULL) && (cdmax != 5'h00)
      && (dss == `DSS_BYPASS);
   wire split_skip = (cfg[1:0] == `CFG_BOTH) && (ats_mode == `ATS_SPLIT)
      && (cdmax != 5'h00) && (dss == `DSS_BYPASS);
   wire s2_en = cfg[1];

   // ********************************
   // axi4-lite slave
   // ********************************
   logic aw_held_q;
   logic w_held_q;
   logic [5:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   wire wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
   wire [31:0] wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
   wire [31:0] wmerge_ctrl = ({30'h0, gctrl_q} & ~wmask) | (w_data_q & wmask);
   wire [31:0] wmerge_cfg = ({11'h0, scfg_q} & ~wmask) | (w_data_q & wmask);
   wire [31:0] wmerge_ovr = ({24'h0, ovr_q} & ~wmask) | (w_data_q & wmask);
   wire [31:0] wmerge_fix = ({24'h0, fixed_q} & ~wmask) | (w_data_q & wmask);
   wire wr_known = (aw_addr_q == `OFF_GLOBAL_CTRL) || (aw_addr_q == `OFF_STREAM_CFG)
      || (aw_addr_q == `OFF_OVERRIDE) || (aw_addr_q == `OFF_FIXED_ATTR);
   wire [5:0] ra = s_axi_araddr;
   wire rd_known = (ra <= `OFF_FAULT_COUNT) && (ra[1:0] == 2'h0);
   logic [31:0] rd_mux;
   always_comb
   begin
      unique case (ra)
         `OFF_GLOBAL_CTRL: rd_mux = {30'h0, gctrl_q};
         `OFF_STREAM_CFG: rd_mux = {11'h0, scfg_q};
         `OFF_OVERRIDE: rd_mux = {24'h0, ovr_q};
         `OFF_FIXED_ATTR: rd_mux = {24'h0, fixed_q};
         `OFF_STATUS: rd_mux = {28'h0, misconfig_q, split_skip, full_skip, split_mode};
         `OFF_REQ_COUNT: rd_mux = req_cnt_q;
         `OFF_XLT_COUNT: rd_mux = xlt_cnt_q;
         `OFF_FAULT_COUNT: rd_mux = flt_cnt_q;
         default: rd_mux = 32'h0;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         aw_addr_q <= 6'h00;
         w_data_q <= 32'h0;
         w_strb_q <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `RESP_OKAY;
      end
      else
      begin
         s_axi_awready <= !aw_held_q && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !w_held_q && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (wr_fire)
         begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         gctrl_q <= `RST_GLOBAL_CTRL;
         scfg_q <= `RST_STREAM_CFG;
         ovr_q <= `RST_OVERRIDE;
         fixed_q <= `RST_FIXED_ATTR;
      end
      else if (wr_fire)
      begin
         if (aw_addr_q == `OFF_GLOBAL_CTRL)
            gctrl_q <= wmerge_ctrl[1:0];
         if (aw_addr_q == `OFF_STREAM_CFG)
            scfg_q <= wmerge_cfg[20:0];
         if (aw_addr_q == `OFF_OVERRIDE)
            ovr_q <= wmerge_ovr[7:0];
         if (aw_addr_q == `OFF_FIXED_ATTR)
            fixed_q <= wmerge_fix[7:0];
      end
   end

   // ********************************
   // translation engine
   // ********************************
   ats_resp_pkg::state_t state_q;
   ats_resp_pkg::xlat_req_t req_q;
   ats_resp_pkg::xlated_txn_t txn_q;
   ats_resp_pkg::walk_res_t s1_q;
   logic skip_q;

   // requests without pasid take the skip paths when full_skip or split_skip is set; pasid traffic walks normally
   wire no_pasid = !req.pasid_present;
   wire id_map = no_pasid && full_skip && !s2_en;
   wire s2_only_req = no_pasid && (split_skip || (full_skip && s2_en));
   wire [5:0] ident_size = `OUT_ADDR_BITS;
   wire wr_grant_s2 = walk_res.wr && !req_q.no_write;
   wire [7:0] s2_attr_skip = attr_combine(in_attr, walk_res.attr);
   wire [7:0] nest_attr = attr_combine(s1_q.attr, walk_res.attr);
   wire [7:0] txn_in_attr = attr_en ? txn_q.attr : fixed_q;
   wire [63:0] nest_addr = split_mode ? s1_q.out_addr : walk_res.out_addr;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_q <= ats_resp_pkg::ST_IDLE;
         req_q <= '0;
         txn_q <= '0;
         s1_q <= '0;
         skip_q <= 1'b0;
         req_ready <= 1'b0;
         txn_ready <= 1'b0;
         cpl_valid <= 1'b0;
         cpl <= '0;
         out_valid <= 1'b0;
         out_txn <= '0;
         walk_valid <= 1'b0;
         walk_stage2 <= 1'b0;
         walk_addr <= 64'h0;
         req_cnt_q <= 32'h0;
         xlt_cnt_q <= 32'h0;
         flt_cnt_q <= 32'h0;
         misconfig_q <= 1'b0;
      end
      else
      begin
         req_ready <= 1'b0;
         txn_ready <= 1'b0;
         if (cpl_valid && cpl_ready)
            cpl_valid <= 1'b0;
         if (out_valid && out_ready)
            out_valid <= 1'b0;
         if (walk_valid && walk_done)
            walk_valid <= 1'b0;
         // split mode without check enable is flagged, and honoured only on the split skip path
         misconfig_q <= (ats_mode == `ATS_SPLIT) && !check_en;
         unique case (state_q)
            ats_resp_pkg::ST_IDLE:
            begin
               if (req_valid && !cpl_valid)
               begin
                  req_ready <= 1'b1;
                  req_q <= req;
                  req_cnt_q <= req_cnt_q + 32'h1;
                  skip_q <= s2_only_req;
                  if (id_map)
                  begin
                     cpl <= '0;
                     cpl.addr <= req.addr;
                     cpl.size_log2 <= ident_size;
                     cpl.attr <= in_attr;
                     cpl.rd <= 1'b1;
                     cpl.wr <= 1'b1;
                     cpl_valid <= 1'b1;
                     state_q <= ats_resp_pkg::ST_CPL;
                  end
                  else
                  begin
                     walk_valid <= 1'b1;
                     walk_stage2 <= s2_only_req || !cfg[0];
                     walk_addr <= req.addr;
                     state_q <= (s2_only_req || !cfg[0]) ? ats_resp_pkg::ST_S2
                        : ats_resp_pkg::ST_S1;
                  end
               end
               else if (txn_valid && !out_valid)
               begin
                  txn_ready <= 1'b1;
                  txn_q <= txn;
                  xlt_cnt_q <= xlt_cnt_q + 32'h1;
                  if (check_en && ats_mode == `ATS_SPLIT)
                  begin
                     walk_valid <= 1'b1;
                     walk_stage2 <= 1'b1;
                     walk_addr <= txn.addr;
                     state_q <= ats_resp_pkg::ST_TXN;
                  end
                  else
                  begin
                     out_valid <= 1'b1;
                     out_txn.addr <= txn.addr;
                     out_txn.attr <= attr_en ? txn.attr : fixed_q;
                     out_txn.is_write <= txn.is_write;
                     // stream not enabled for ats is refused when checking
                     out_txn.fault <= check_en && (ats_mode != `ATS_FULL);
                  end
               end
            end
            ats_resp_pkg::ST_S1:
            begin
               if (walk_done)
               begin
                  s1_q <= walk_res;
                  if (walk_res.fault || !s2_en)
                  begin
                     cpl <= '0;
                     cpl.addr <= walk_res.out_addr;
                     cpl.size_log2 <= walk_res.size_log2;
                     cpl.attr <= walk_res.attr;
                     cpl.rd <= walk_res.rd && !walk_res.fault;
                     cpl.wr <= walk_res.wr && !req_q.no_write && !walk_res.fault;
                     cpl.exe <= walk_res.exe && req_q.exe_req && !walk_res.fault;
                     cpl.priv <= req_q.priv_req;
                     cpl_valid <= 1'b1;
                     state_q <= ats_resp_pkg::ST_CPL;
                  end
                  else
                  begin
                     walk_valid <= 1'b1;
                     walk_stage2 <= 1'b1;
                     walk_addr <= walk_res.out_addr;
                     state_q <= ats_resp_pkg::ST_S2;
                  end
               end
            end
            ats_resp_pkg::ST_S2:
            begin
               if (walk_done)
               begin
                  cpl <= '0;
                  cpl_valid <= 1'b1;
                  state_q <= ats_resp_pkg::ST_CPL;
                  if (skip_q || !cfg[0])
                  begin
                     // split skip returns the intermediate address unchanged
                     cpl.addr <= (split_skip && !req_q.pasid_present) ? req_q.addr
                        : walk_res.out_addr;
                     cpl.size_log2 <= walk_res.size_log2;
                     cpl.attr <= s2_attr_skip;
                     cpl.rd <= walk_res.rd && !walk_res.fault;
                     cpl.wr <= wr_grant_s2 && !walk_res.fault;
                  end
                  else
                  begin
                     cpl.addr <= nest_addr;
                     cpl.size_log2 <= size_min(s1_q.size_log2, walk_res.size_log2);
                     cpl.attr <= nest_attr;
                     cpl.rd <= s1_q.rd && walk_res.rd && !walk_res.fault;
                     cpl.wr <= s1_q.wr && walk_res.wr && !req_q.no_write
                        && !walk_res.fault;
                     cpl.exe <= s1_q.exe && walk_res.exe && req_q.exe_req
                        && !walk_res.fault;
                     cpl.priv <= req_q.priv_req;
                  end
               end
            end
            ats_resp_pkg::ST_CPL:
            begin
               if (!cpl_valid)
                  state_q <= ats_resp_pkg::ST_IDLE;
            end
            ats_resp_pkg::ST_TXN:
            begin
               if (walk_done)
               begin
                  out_valid <= 1'b1;
                  out_txn.addr <= walk_res.out_addr;
                  out_txn.attr <= attr_combine(txn_in_attr, walk_res.attr);
                  out_txn.is_write <= txn_q.is_write;
                  out_txn.fault <= walk_res.fault || (txn_q.is_write ? !walk_res.wr
                     : !walk_res.rd);
                  if (walk_res.fault)
                     flt_cnt_q <= flt_cnt_q + 32'h1;
                  state_q <= ats_resp_pkg::ST_IDLE;
               end
            end
            default:
               state_q <= ats_resp_pkg::ST_IDLE;
         endcase
      end
   end
endmodule

// [tb/ats_resp_props.sv]
// concurrent checks on the ats responder ports
module ats_resp_checker
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic req_ready,
   input wire logic cpl_valid,
   input wire ats_resp_pkg::xlat_cpl_t cpl,
   input wire logic cpl_ready,
   input wire logic out_valid,
   input wire ats_resp_pkg::out_txn_t out_txn,
   input wire logic out_ready,
   input wire logic walk_valid,
   input wire logic [63:0] walk_addr,
   input wire logic walk_done
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ******************************
   // properties
   // ******************************
   property p_nosnoop; cpl_valid |-> !cpl.no_snoop; endproperty
   property p_untrans; cpl_valid |-> !cpl.untranslated; endproperty
   property p_cpl_hold; cpl_valid && !cpl_ready |=> cpl_valid && $stable(cpl); endproperty
   property p_out_hold; out_valid && !out_ready |=> out_valid && $stable(out_txn); endproperty
   property p_walk_hold;
      walk_valid && !walk_done |=> walk_valid && $stable(walk_addr);
   endproperty
   // two short walks fit well inside 64
   property p_cpl_bound; req_ready |-> ##[0:64] cpl_valid; endproperty
   property p_req_pulse; req_ready |=> !req_ready; endproperty
   property p_perm; cpl_valid && !cpl.rd |-> !cpl.wr && !cpl.exe; endproperty
   a_nosnoop: assert property (p_nosnoop)
      else $error("no-snoop set in completion");
   a_untrans: assert property (p_untrans)
      else $error("untranslated flag set in completion");
   a_cpl_hold: assert property (p_cpl_hold)
      else $error("completion changed before taken");
   a_out_hold: assert property (p_out_hold)
      else $error("output transaction changed before taken");
   a_walk_hold: assert property (p_walk_hold)
      else $error("walk query changed before done");
   a_cpl_bound: assert property (p_cpl_bound)
      else $error("completion late");
   a_req_pulse: assert property (p_req_pulse)
      else $error("request ready longer than one cycle");
   a_perm: assert property (p_perm)
      else $error("write or execute without read");
   c_cpl: cover property (cpl_valid && cpl_ready);
   c_out: cover property (out_valid && out_ready);
   c_walk2: cover property (walk_valid && walk_done ##1 walk_valid);
endmodule

bind ats_split_stage_responder ats_resp_checker checker_i
(
   .aclk(aclk),
   .aresetn(aresetn),
   .req_ready(req_ready),
   .cpl_valid(cpl_valid),
   .cpl(cpl),
   .cpl_ready(cpl_ready),
   .out_valid(out_valid),
   .out_txn(out_txn),
   .out_ready(out_ready),
   .walk_valid(walk_valid),
   .walk_addr(walk_addr),
   .walk_done(walk_done)
);

// [tb/walker_model.sv]
// table walker stand-in with random latency
module walker_model
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic walk_valid,
   input wire logic walk_stage2,
   input wire logic [63:0] walk_addr,
   output logic walk_done,
   output ats_resp_pkg::walk_res_t walk_res
);
   timeunit 1ns;
   timeprecision 1ps;
   int wait_q;
   always @(posedge aclk)
   begin
      if (!aresetn || walk_done || !walk_valid)
      begin
         walk_done <= 1'b0;
         walk_res <= ~walk_res; // released: inverted on every idle cycle
         wait_q <= $urandom_range(3);
      end
      else if (wait_q > 0)
         wait_q <= wait_q - 1;
      else
      begin
         walk_done <= 1'b1;
         walk_res.out_addr <= walk_addr ^ (walk_stage2 ? 64'h1000000 : 64'h200000);
         walk_res.size_log2 <= walk_stage2 ? 6'h15 : (walk_addr[12] ? 6'h1E : 6'h0C);
         walk_res.attr <= 8'h33;
         walk_res.rd <= 1'b1;
         walk_res.wr <= ~walk_addr[13];
         walk_res.exe <= 1'b0;
         walk_res.fault <= 1'b0;
      end
   end
endmodule

// [tb/testbench.sv]
// self-checking bench for the ats split-stage responder
`include "ats_resp_consts.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk, aresetn;
   logic [5:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic req_valid, req_ready, cpl_valid, cpl_ready, txn_valid, txn_ready, out_valid, out_ready;
   ats_resp_pkg::xlat_req_t req;
   ats_resp_pkg::xlat_cpl_t cpl, c;
   ats_resp_pkg::xlated_txn_t txn;
   ats_resp_pkg::out_txn_t out_txn, o;
   logic walk_valid, walk_stage2, walk_done;
   logic [63:0] walk_addr, a;
   ats_resp_pkg::walk_res_t walk_res;
   logic [31:0] d;
   logic [1:0] r;
   int err_count, total_checks;
   ats_split_stage_responder ats_split_stage_responder_i (.*);
   walker_model walker_model_i (.*);
   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   // ******************************
   // helpers
   // ******************************
   task report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task chk(input bit ok, input string m);
      total_checks++;
      if (!ok)
      begin
         $display("FAIL %0t %s", $time, m);
         err_count++;
      end
   endtask
   task guard(input int n);
      if (n >= 200)
      begin
         err_count++;
         report_and_stop();
      end
      @(posedge aclk);
   endtask
   function automatic logic [63:0] xf(input logic [63:0] v, input logic st2);
      return v ^ (st2 ? 64'h1000000 : 64'h200000);
   endfunction
   function automatic logic [31:0] cfgw(input logic [2:0] k, input logic [1:0] e,
                                        input logic [1:0] s, input logic [4:0] m);
      return {15'h0000, m, 2'h0, s, 2'h0, e, 1'b0, k};
   endfunction
   task axw(input logic [5:0] ad, input logic [31:0] dd, output logic [1:0] rr);
      int n;
      n = 0;
      s_axi_awaddr <= ad;
      s_axi_wdata <= dd;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_awready === 1'b1) s_axi_awaddr <= ~ad;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wdata <= ~dd;
      end while (s_axi_bvalid !== 1'b1 && n < 200);
      rr = s_axi_bresp;
      s_axi_bready <= 1'b0;
      guard(n);
   endtask
   task axr(input logic [5:0] ad, output logic [31:0] dd, output logic [1:0] rr);
      int n;
      n = 0;
      s_axi_araddr <= ad;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         if (s_axi_arready === 1'b1) s_axi_araddr <= ~ad;
      end while (s_axi_rvalid !== 1'b1 && n < 200);
      dd = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 1'b0;
      guard(n);
   endtask
   task do_req(input logic [63:0] ad, input logic p);
      int n;
      n = 0;
      req_valid <= 1'b1;
      req <= {ad, 1'b0, p, 2'b00};
      cpl_ready <= 1'b1;
      do begin @(posedge aclk); n++; end while (req_ready !== 1'b1 && n < 200);
      req_valid <= 1'b0;
      req <= {~ad, 1'b1, ~p, 2'b11};
      while (cpl_valid !== 1'b1 && n < 200) begin @(posedge aclk); n++; end
      c = cpl;
      cpl_ready <= 1'b0;
      guard(n);
   endtask
   task do_txn(input logic [63:0] ad);
      int n;
      n = 0;
      txn_valid <= 1'b1;
      txn <= {ad, 8'hFF, 1'b1};
      out_ready <= 1'b1;
      do begin @(posedge aclk); n++; end while (txn_ready !== 1'b1 && n < 200);
      txn_valid <= 1'b0;
      txn <= {~ad, 8'h00, 1'b0};
      while (out_valid !== 1'b1 && n < 200) begin @(posedge aclk); n++; end
      o = out_txn;
      out_ready <= 1'b0;
      guard(n);
   endtask
   // ******************************
   // main sequence
   // ******************************
   initial
   begin
      {aresetn, s_axi_awaddr, s_axi_araddr, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_wdata, s_axi_arvalid, s_axi_rready, req_valid, cpl_ready, txn_valid} = '0;
      {out_ready, req, txn} = '0;
      s_axi_wstrb = 4'hF;
      err_count = 0;
      total_checks = 0;
      void'($urandom(32'h187cc341));
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      axr(`OFF_FIXED_ATTR, d, r);
      chk(d[7:0] === `RST_FIXED_ATTR, "fixed attribute reset");
      axr(`OFF_STREAM_CFG, d, r);
      chk(d[20:0] === `RST_STREAM_CFG, "stream config reset");
      axr(6'h20, d, r);
      chk(r === `RESP_SLVERR, "unmapped read accepted");
      axw(`OFF_GLOBAL_CTRL, 32'h3, r);
      for (int i = 0; i < 8; i++)
      begin
         a = {16'h0000, 16'($urandom), $urandom} & ~64'hFFF;
         a[13:12] = 2'(i);
         axw(`OFF_STREAM_CFG, cfgw(`CFG_NESTED, `ATS_SPLIT, 2'h0, 5'h00), r);
         do_req(a, 1'b1);
         chk(c.addr === xf(a, 1'b0) && r === `RESP_OKAY, "split completion address");
         chk(c.wr === ~a[13] && c.rd === 1'b1, "split permissions");
         chk(c.size_log2 === (a[12] ? 6'h15 : 6'h0C), "split size");
         chk(c.no_snoop === 1'b0, "no-snoop");
         do_txn(a);
         chk(o.addr === xf(a, 1'b1) && o.fault === a[13], "split translated txn");
         axw(`OFF_STREAM_CFG, cfgw(3'h1, `ATS_FULL, `DSS_BYPASS, 5'h01), r);
         do_req(a, 1'b0);
         chk(c.addr === a && c.rd === 1'b1 && c.wr === 1'b1, "identity completion");
         chk(c.size_log2 === `OUT_ADDR_BITS, "identity size");
         chk(c.exe === 1'b0 && c.priv === 1'b0, "skip exe priv");
         chk(c.attr === `RST_FIXED_ATTR, "identity attribute");
         axw(`OFF_STREAM_CFG, cfgw(3'h3, `ATS_FULL, `DSS_BYPASS, 5'h01), r);
         do_req(a, 1'b0);
         chk(c.addr === xf(a, 1'b1), "stage 2 only completion");
         do_txn(a);
         chk(o.addr === a && o.fault === 1'b0, "full mode translated txn");
         axw(`OFF_STREAM_CFG, cfgw(`CFG_NESTED, `ATS_SPLIT, `DSS_BYPASS, 5'h01), r);
         do_req(a, 1'b0);
         chk(c.addr === a && c.untranslated === 1'b0, "split skip address");
         chk(c.wr === ~a[13] && c.rd === 1'b1, "split skip permissions");
         chk(c.size_log2 === 6'h15, "split skip size");
         chk(c.exe === 1'b0 && c.priv === 1'b0, "split skip exe priv");
         do_txn(a);
         chk(o.addr === xf(a, 1'b1), "split skip translated txn");
      end
      report_and_stop();
   end
endmodule
